// file: rtl/vsc_defs.svh
`ifndef VSC_DEFS_SVH
`define VSC_DEFS_SVH

// Register byte offsets
`define VSC_OFF_MODE_BASE 12'h000
`define VSC_MODE_PAGE     5'h00
`define VSC_OFF_NVR       12'h100
`define VSC_OFF_FVR       12'h104
`define VSC_OFF_ISR       12'h108
`define VSC_OFF_IPR       12'h10c
`define VSC_OFF_IMR       12'h110
`define VSC_OFF_CISR      12'h114
`define VSC_OFF_GMASK     12'h118
`define VSC_OFF_FFORCE    12'h11c
`define VSC_OFF_IECR      12'h120
`define VSC_OFF_IDCR      12'h124
`define VSC_OFF_ICCR      12'h128
`define VSC_OFF_ISCR      12'h12c

// Source allocation
`define VSC_SRC_FAST      5'h00
`define VSC_SRC_SYS       5'h01

// Mode register fields
`define VSC_PRIO_LSB      0
`define VSC_PRIO_MSB      2
`define VSC_TRIG_LSB      5
`define VSC_TRIG_MSB      6

// Core request image fields
`define VSC_CISR_NORMAL   0
`define VSC_CISR_FAST     1

// Reset values
`define VSC_RST_WORD      32'h0000_0000
`define VSC_RST_MODE      5'h00
`define VSC_RST_NUM       5'h00

`endif

// file: rtl/vsc_pkg.sv
package vsc_pkg;

  // Trigger type: bit 1 = active high / rising, bit 0 = edge
  typedef enum logic [1:0]
  {
    VSC_TRIG_LOW_LEVEL   = 2'h0,
    VSC_TRIG_FALL_EDGE   = 2'h1,
    VSC_TRIG_HIGH_LEVEL  = 2'h2,
    VSC_TRIG_RISE_EDGE   = 2'h3
  } vsc_trig_t;

  typedef struct packed
  {
    vsc_trig_t   trig;
    logic [2:0]  prio;
  } vsc_mode_t;

  typedef struct packed
  {
    logic        fast_n;
    logic        normal_n;
  } vsc_core_req_t;

endpackage

// file: rtl/vsc_source_ctrl.sv
`timescale 1ns/100ps
`include "vsc_defs.svh"

module vsc_source_ctrl
  import vsc_pkg::*;
#(
  parameter int          NSYS     = 4,
  parameter bit          HAS_FAST = 1'b1,
  parameter logic [31:0] EXT_MASK = 32'hf000_0001
)
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  // Wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [11:0]       i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic      [31:0]       o_wb_dat,
  output logic                   o_wb_ack,
  // Interrupt sources
  input  wire logic              i_fast_request_pin,
  input  wire logic [NSYS-1:0]   i_system_source,
  input  wire logic [31:2]       i_peripheral_sources,
  input  wire logic [31:2]       i_external_request_pins,
  // Processor side
  output logic                   o_core_normal_request_n,
  output logic                   o_core_fast_request_n,
  output logic                   o_wakeup,
  output logic      [4:0]        o_current_number,
  output logic                   o_normal_vector_read,
  output logic                   o_fast_vector_read
);

  // Bus decode
  logic              bus_req;
  logic              wr_req;
  logic              rd_req;
  logic              full_wr;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              hit;
  logic              nvr_rd;
  logic              fvr_rd;

  // Source state
  vsc_mode_t         mode_reg [32];
  logic [31:0]       mask_reg;
  logic [31:0]       fforce_reg;
  logic              gmask_reg;
  logic [31:0]       raw_line;
  logic [31:0]       sync1_reg;
  logic [31:0]       sync2_reg;
  logic [31:0]       prev_reg;
  logic [31:0]       latch_reg;
  logic [31:0]       pend;
  logic [31:0]       is_edge;
  logic [31:0]       cmd_set;
  logic [31:0]       cmd_clr;
  logic [31:0]       auto_clr;
  logic [4:0]        current_reg;
  logic [4:0]        sel_num;
  logic              sel_valid;
  logic              normal_act;
  logic              fast_act;
  vsc_core_req_t     core_reg;
  logic              wake_reg;

  // Single-cycle answer; side effects at the edge the request is taken
  // Held request is not taken again while ack stands
  assign bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign wr_req  = bus_req & i_wb_we;
  assign rd_req  = bus_req & ~i_wb_we;
  // Command registers act only on full-word writes to avoid partial masks
  assign full_wr = wr_req & (i_wb_sel == 4'hf);
  assign nvr_rd  = rd_req & (i_wb_adr == `VSC_OFF_NVR);
  assign fvr_rd  = rd_req & (i_wb_adr == `VSC_OFF_FVR);

  // Source allocation
  always_comb
  begin
    raw_line          = '0;
    raw_line[`VSC_SRC_FAST] = HAS_FAST ? i_fast_request_pin : 1'b0;
    raw_line[`VSC_SRC_SYS]  = |i_system_source;
    // Bit index is the peripheral identifier
    for (int k = 2; k < 32; k++)
    begin
      raw_line[k] = EXT_MASK[k] ? i_external_request_pins[k]
                                : i_peripheral_sources[k];
    end
  end

  // Synchroniser and edge history, all sources, free-running clock
  // Internal lines share the path so all sources keep one latency
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_reg <= `VSC_RST_WORD;
      sync2_reg <= `VSC_RST_WORD;
      prev_reg  <= `VSC_RST_WORD;
    end
    else
    begin
      sync1_reg <= raw_line;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Per-source condition and edge latch
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_src
      logic lvl;
      logic edge_hit;
      logic usable;
      vsc_trig_t t;
      logic hold_reg;

      assign t      = mode_reg[g].trig;
      assign usable = (g != 0) || HAS_FAST;
      // Internal polarity fixed active high
      assign lvl    = (EXT_MASK[g] && !t[1]) ? ~sync2_reg[g] : sync2_reg[g];
      assign edge_hit = (EXT_MASK[g] && !t[1]) ? (prev_reg[g] & ~sync2_reg[g])
                                               : (~prev_reg[g] & sync2_reg[g]);
      assign is_edge[g] = t[0];
      assign cmd_set[g] = full_wr & (i_wb_adr == `VSC_OFF_ISCR) & i_wb_dat[g];
      assign cmd_clr[g] = full_wr & (i_wb_adr == `VSC_OFF_ICCR) & i_wb_dat[g];
      assign pend[g]    = usable & (is_edge[g] ? latch_reg[g] : lvl);
      // Local flop keeps one driver per bit of the shared vector
      assign latch_reg[g] = hold_reg;

      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
          hold_reg <= 1'b0;
        else if (!is_edge[g])
          hold_reg <= 1'b0;
        else if (edge_hit || cmd_set[g])
          hold_reg <= 1'b1;
        else if (cmd_clr[g] || auto_clr[g])
          hold_reg <= 1'b0;
      end
    end
  endgenerate

  // Priority pick at vector read: highest level, lowest number on ties
  // Source 0 never competes; it only feeds the fast line
  always_comb
  begin
    logic [2:0] best;
    best      = 3'h0;
    sel_num   = `VSC_RST_NUM;
    sel_valid = 1'b0;
    for (int k = 31; k >= 1; k--)
    begin
      if (pend[k] && mask_reg[k] && !fforce_reg[k] &&
          (!sel_valid || mode_reg[k].prio >= best))
      begin
        best      = mode_reg[k].prio;
        sel_num   = 5'(k);
        sel_valid = 1'b1;
      end
    end
  end

  // Auto clear the chosen source at NVR read, never a forced one; FVR read always clears source 0
  always_comb
  begin
    auto_clr = '0;
    if (nvr_rd && sel_valid && !fforce_reg[sel_num])
      auto_clr[sel_num] = 1'b1;
    if (fvr_rd)
      auto_clr[`VSC_SRC_FAST] = 1'b1;
  end

  // Enable mask
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      mask_reg <= `VSC_RST_WORD;
    else if (full_wr && i_wb_adr == `VSC_OFF_IECR)
      mask_reg <= mask_reg | i_wb_dat;
    else if (full_wr && i_wb_adr == `VSC_OFF_IDCR)
      mask_reg <= mask_reg & ~i_wb_dat;
  end

  // Mode, forcing and general mask storage
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int k = 0; k < 32; k++)
        mode_reg[k] <= `VSC_RST_MODE;
      fforce_reg <= `VSC_RST_WORD;
      gmask_reg  <= 1'b0;
    end
    else if (wr_req && i_wb_sel[0])
    begin
      if (i_wb_adr[11:7] == `VSC_MODE_PAGE && i_wb_adr[1:0] == 2'h0)
      begin
        mode_reg[i_wb_adr[6:2]].prio <= i_wb_dat[`VSC_PRIO_MSB:`VSC_PRIO_LSB];
        mode_reg[i_wb_adr[6:2]].trig <= vsc_trig_t'(i_wb_dat[`VSC_TRIG_MSB:`VSC_TRIG_LSB]);
      end
      if (i_wb_adr == `VSC_OFF_GMASK)
        gmask_reg <= i_wb_dat[0];
      if (i_wb_adr == `VSC_OFF_FFORCE && (i_wb_sel == 4'hf))
        fforce_reg <= i_wb_dat;
    end
  end

  // Current interrupt number latched at the normal vector read
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      current_reg <= `VSC_RST_NUM;
    else if (nvr_rd && sel_valid)
      current_reg <= sel_num;
  end

  // Requests; source 0 and forced sources go to the fast line
  assign normal_act = |(pend & mask_reg & ~fforce_reg & 32'hffff_fffe);
  assign fast_act   = (pend[`VSC_SRC_FAST] & mask_reg[`VSC_SRC_FAST]) |
                      (|(pend & mask_reg & fforce_reg));
  // Wake-up skips the general mask so an event still rouses an idle core

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      core_reg <= '{fast_n: 1'b1, normal_n: 1'b1};
      wake_reg <= 1'b0;
    end
    else
    begin
      core_reg.normal_n <= ~(normal_act & ~gmask_reg);
      core_reg.fast_n   <= ~(fast_act & ~gmask_reg);
      wake_reg          <= normal_act | fast_act;
    end
  end

  // Read mux
  // Unmapped reads return zero and are still acked
  always_comb
  begin
    hit        = 1'b1;
    rdata_next = `VSC_RST_WORD;
    if (i_wb_adr[11:7] == `VSC_MODE_PAGE)
    begin
      rdata_next[`VSC_PRIO_MSB:`VSC_PRIO_LSB] = mode_reg[i_wb_adr[6:2]].prio;
      rdata_next[`VSC_TRIG_MSB:`VSC_TRIG_LSB] = mode_reg[i_wb_adr[6:2]].trig;
    end
    else
    begin
      unique case (i_wb_adr)
        `VSC_OFF_NVR:    rdata_next[4:0] = sel_valid ? sel_num : current_reg;
        `VSC_OFF_FVR:    rdata_next[4:0] = `VSC_SRC_FAST;
        `VSC_OFF_ISR:    rdata_next[4:0] = current_reg;
        `VSC_OFF_IPR:    rdata_next = pend;
        `VSC_OFF_IMR:    rdata_next = mask_reg;
        `VSC_OFF_CISR:
        begin
          rdata_next[`VSC_CISR_NORMAL] = ~core_reg.normal_n;
          rdata_next[`VSC_CISR_FAST]   = ~core_reg.fast_n;
        end
        `VSC_OFF_GMASK:  rdata_next[0] = gmask_reg;
        `VSC_OFF_FFORCE: rdata_next = fforce_reg;
        `VSC_OFF_IECR, `VSC_OFF_IDCR, `VSC_OFF_ICCR, `VSC_OFF_ISCR:
          rdata_next = `VSC_RST_WORD;
        default:         hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= `VSC_RST_WORD;
    end
    else
    begin
      ack_reg <= bus_req;
      if (rd_req)
        rdata_reg <= hit ? rdata_next : `VSC_RST_WORD;
    end
  end

  // Vector read strobes for the priority and vectoring logic
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_normal_vector_read <= 1'b0;
      o_fast_vector_read   <= 1'b0;
    end
    else
    begin
      o_normal_vector_read <= nvr_rd;
      o_fast_vector_read   <= fvr_rd;
    end
  end

  assign o_wb_ack                = ack_reg;
  assign o_wb_dat                = rdata_reg;
  assign o_core_normal_request_n = core_reg.normal_n;
  assign o_core_fast_request_n   = core_reg.fast_n;
  assign o_wakeup                = wake_reg;
  assign o_current_number        = current_reg;

endmodule

// file: verif/vsc_source_ctrl_chk.sv
`timescale 1ns/100ps
module vsc_source_ctrl_chk
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  // Bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Processor side
  input wire logic        o_core_normal_request_n,
  input wire logic        o_core_fast_request_n,
  input wire logic        o_wakeup,
  input wire logic [4:0]  o_current_number,
  input wire logic        o_normal_vector_read,
  input wire logic        o_fast_vector_read
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Steps of a bus read: request taken, then its place
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_rd(a);
    s_take ##0 (!i_wb_we && i_wb_adr == a);
  endsequence
  sequence s_rd_void;
    s_take ##0 (!i_wb_we && i_wb_adr >= 12'h130);
  endsequence

  property p_ack;
    s_take |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  property p_wake;
    (!o_core_normal_request_n || !o_core_fast_request_n) |-> o_wakeup;
  endproperty
  property p_nvr;
    s_rd(12'h100) |=> o_normal_vector_read && o_wb_dat == {27'h0, o_current_number};
  endproperty
  property p_nvr_cause;
    o_normal_vector_read |-> o_wb_ack && $past(i_wb_adr) == 12'h100;
  endproperty
  property p_fvr;
    s_rd(12'h104) |=> o_fast_vector_read && o_wb_dat == 32'h0;
  endproperty
  property p_isr;
    s_rd(12'h108) |=> o_wb_dat == {27'h0, o_current_number};
  endproperty
  property p_cisr;
    s_rd(12'h114) |=> o_wb_dat[0] == !$past(o_core_normal_request_n)
      && o_wb_dat[1] == !$past(o_core_fast_request_n);
  endproperty
  property p_void;
    s_rd_void |=> o_wb_dat == 32'h0;
  endproperty
  // Current number moves only on a vector read
  property p_cur;
    !$stable(o_current_number) |-> o_normal_vector_read;
  endproperty

  a_ack: assert property (p_ack) else $error("ack timing");
  a_wake: assert property (p_wake) else $error("wake missing");
  a_nvr: assert property (p_nvr) else $error("nvr read");
  a_nvr_cause: assert property (p_nvr_cause) else $error("nvr strobe");
  a_fvr: assert property (p_fvr) else $error("fvr read");
  a_isr: assert property (p_isr) else $error("isr read");
  a_cisr: assert property (p_cisr) else $error("cisr image");
  a_void: assert property (p_void) else $error("unmapped read");
  a_cur: assert property (p_cur) else $error("current moved");
endmodule

bind vsc_source_ctrl vsc_source_ctrl_chk chk_u (.*);

// file: verif/vsc_core_model.sv
`timescale 1ns/100ps
module vsc_core_model
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // Lines from the controller
  input  wire logic i_normal_request_n,
  input  wire logic i_fast_request_n,
  input  wire logic i_wakeup,
  // Bench side
  input  wire logic i_sleep,
  output logic      o_asleep,
  output logic      o_req_seen
);
  // Wake-up beats a new sleep request, so no event is lost
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_asleep <= 1'b0;
    else if (i_wakeup)
      o_asleep <= 1'b0;
    else if (i_sleep)
      o_asleep <= 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_req_seen <= 1'b0;
    else
      o_req_seen <= !i_normal_request_n || !i_fast_request_n;
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/100ps
module tb;
  import vsc_pkg::*;
  // Design inputs
  logic        i_clk    = 1'b0;
  logic        i_arst_n = 1'b0;
  logic        i_wb_cyc = 1'b0;
  logic        i_wb_stb = 1'b0;
  logic        i_wb_we  = 1'b0;
  logic [11:0] i_wb_adr = 12'h000;
  logic [3:0]  i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0;
  // External lines idle high
  logic        i_fast_request_pin      = 1'b1;
  logic [3:0]  i_system_source         = 4'h0;
  logic [31:2] i_peripheral_sources    = 30'h0;
  logic [31:2] i_external_request_pins = 30'h3fff_ffff;
  // Design outputs
  logic [31:0] o_wb_dat;
  logic [4:0]  o_current_number;
  logic        o_wb_ack, o_core_normal_request_n, o_core_fast_request_n, o_wakeup;
  logic        o_normal_vector_read, o_fast_vector_read;
  // Bench state
  logic        sleep = 1'b0;
  logic        asleep, req_seen;
  logic [31:0] q;
  int          fails = 0, n_tests = 0, cyc_cnt = 0;

  always #50 i_clk = ~i_clk;

  vsc_source_ctrl dut_u (.*);
  vsc_core_model core_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_normal_request_n(o_core_normal_request_n), .i_fast_request_n(o_core_fast_request_n),
    .i_wakeup(o_wakeup), .i_sleep(sleep), .o_asleep(asleep), .o_req_seen(req_seen));

  task automatic end_of_test;
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  // Classic cycle; waits for ack, bounded
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    @(posedge i_clk);
    while (o_wb_ack !== 1'b1 && t < 20)
    begin
      @(posedge i_clk);
      t++;
    end
    q = o_wb_dat;
    if (t == 20)
      fails++;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic md(input int n, input logic [1:0] tr, input logic [2:0] pr);
    wb(1'b1, 12'(4 * n), {25'h0, tr, 2'h0, pr});
  endtask

  task automatic t_mask;
    rc("imr0", 12'h110, 32'h0);
    rc("void", 12'h200, 32'h0);
    wb(1'b1, 12'h120, 32'hc000_0003);
    rc("imr", 12'h110, 32'hc000_0003);
    wb(1'b1, 12'h124, 32'h0000_0001);
    rc("imr", 12'h110, 32'hc000_0002);
  endtask
  task automatic t_ext;
    md(31, VSC_TRIG_RISE_EDGE, 3'h5);
    i_external_request_pins[31] <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_external_request_pins[31] <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk("nrq", 32'h0, 32'(o_core_normal_request_n));
    i_external_request_pins[31] <= 1'b0;
    repeat (4) @(posedge i_clk);
    rc("sticky", 12'h10c, 32'h8000_0000);
    rc("nvr", 12'h100, 32'd31);
    rc("ipr", 12'h10c, 32'h0);
    chk("nrq", 32'h1, 32'(o_core_normal_request_n));
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      i_external_request_pins[30] <= ~m[1];
      md(30, 2'(m), 3'h0);
      wb(1'b1, 12'h128, 32'h4000_0000);
      i_external_request_pins[30] <= m[1];
      repeat (4) @(posedge i_clk);
      rc("on", 12'h10c, 32'h4000_0000);
      i_external_request_pins[30] <= ~m[1];
      repeat (4) @(posedge i_clk);
      rc("off", 12'h10c, {1'b0, m[0], 30'h0});
    end
    wb(1'b1, 12'h128, 32'h4000_0000);
  endtask
  task automatic t_setclr;
    md(3, VSC_TRIG_RISE_EDGE, 3'h0);
    i_peripheral_sources[2] <= 1'b1;
    wb(1'b1, 12'h12c, 32'h0000_000c);
    rc("set", 12'h10c, 32'h0000_000c);
    wb(1'b1, 12'h128, 32'h0000_000c);
    rc("clr", 12'h10c, 32'h0000_0004);
    i_peripheral_sources[2] <= 1'b0;
    wb(1'b1, 12'h12c, 32'h0000_0004);
    rc("lvl", 12'h10c, 32'h0);
  endtask
  task automatic t_prio;
    md(4, VSC_TRIG_RISE_EDGE, 3'h7);
    md(5, VSC_TRIG_RISE_EDGE, 3'h7);
    md(6, VSC_TRIG_RISE_EDGE, 3'h7);
    wb(1'b1, 12'h120, 32'h0000_0068);
    wb(1'b1, 12'h12c, 32'h0000_0078);
    rc("nvr", 12'h100, 32'd5);
    rc("ipr", 12'h10c, 32'h0000_0058);
    rc("nvr", 12'h100, 32'd6);
    rc("nvr", 12'h100, 32'd3);
    rc("ipr", 12'h10c, 32'h0000_0010);
    wb(1'b1, 12'h128, 32'h0000_0010);
  endtask
  task automatic t_force;
    wb(1'b1, 12'h11c, 32'h0000_0008);
    wb(1'b1, 12'h12c, 32'h0000_0008);
    chk("frq", 32'h0, 32'(o_core_fast_request_n));
    wb(1'b0, 12'h100, 32'h0);
    rc("forced", 12'h10c, 32'h0000_0008);
    md(0, VSC_TRIG_FALL_EDGE, 3'h0);
    wb(1'b1, 12'h12c, 32'h0000_0001);
    rc("src0", 12'h10c, 32'h0000_0009);
    rc("fvr", 12'h104, 32'h0);
    rc("ipr", 12'h10c, 32'h0000_0008);
    i_fast_request_pin <= 1'b0;
    repeat (4) @(posedge i_clk);
    rc("pin0", 12'h10c, 32'h0000_0009);
    rc("fvr", 12'h104, 32'h0);
    i_fast_request_pin <= 1'b1;
    rc("ipr0", 12'h10c, 32'h0000_0008);
    wb(1'b1, 12'h128, 32'h0000_0008);
    wb(1'b1, 12'h11c, 32'h0);
  endtask
  task automatic t_gmask;
    sleep <= 1'b1;
    wb(1'b1, 12'h118, 32'h1);
    sleep <= 1'b0;
    chk("asleep", 32'h1, 32'(asleep));
    wb(1'b1, 12'h12c, 32'h0000_0008);
    repeat (2) @(posedge i_clk);
    chk("nrq", 32'h1, 32'(o_core_normal_request_n));
    chk("seen", 32'h0, 32'(req_seen));
    chk("asleep", 32'h0, 32'(asleep));
    wb(1'b1, 12'h118, 32'h0);
    rc("cisr", 12'h114, 32'h1);
    wb(1'b1, 12'h128, 32'h0000_0008);
  endtask
  task automatic t_sys;
    i_system_source <= 4'h4;
    repeat (4) @(posedge i_clk);
    rc("sys", 12'h10c, 32'h2);
    chk("nrq", 32'h0, 32'(o_core_normal_request_n));
    i_system_source <= 4'h0;
    repeat (4) @(posedge i_clk);
    chk("nrq", 32'h1, 32'(o_core_normal_request_n));
  endtask

  always @(posedge i_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      fails++;
      end_of_test;
    end
  end

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_mask;
    t_ext;
    t_modes;
    t_setclr;
    t_prio;
    t_force;
    t_gmask;
    t_sys;
    end_of_test;
  end
endmodule
